// [src/tcc_defines.vh]
// constants for the timer capture/compare channel block
`ifndef TCC_DEFINES_VH
`define TCC_DEFINES_VH

// ****************************************
// register byte offsets
// ****************************************
`define TCC_OFF_IOCTL 8'h00
`define TCC_OFF_START 8'h04
`define TCC_OFF_COUNT 8'h08
`define TCC_OFF_GRA 8'h0C
`define TCC_OFF_STATUS 8'h10
`define TCC_OFF_IRQEN 8'h14
`define TCC_OFF_PRESC 8'h18

// ****************************************
// field positions
// ****************************************
`define TCC_CODE_TOP 3
`define TCC_CODE_INIT 2
`define TCC_ST_MATCH 0
`define TCC_ST_OVF 1
`define TCC_ST_CAPT 2
`define TCC_NEVENT 3

// ****************************************
// reset values
// ****************************************
`define TCC_IOCTL_RST 8'h00
`define TCC_PRESC_RST 16'h0000
`define TCC_COUNT_MAX 16'hFFFF

// ****************************************
// axi response codes
// ****************************************
`define TCC_RESP_OKAY 2'h0
`define TCC_RESP_SLVERR 2'h2

`endif

// [src/tcc_tick_div.v]
// count clock divider producing a one-cycle enable pulse
`timescale 1ns/1ps
`default_nettype none

module tcc_tick_div #(
  parameter WIDTH = 16
) (
  input wire aclk,
  input wire aresetn,
  input wire [WIDTH-1:0] divisor,
  output reg tick
);

  reg [WIDTH-1:0] cnt_reg;

  // divisor 0 ticks every cycle; divisor n ticks every n+1 cycles
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= {WIDTH{1'b0}};
      tick <= 1'b0;
    end else if (cnt_reg >= divisor) begin
      cnt_reg <= {WIDTH{1'b0}};
      tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + {{(WIDTH-1){1'b0}}, 1'b1};
      tick <= 1'b0;
    end
  end

endmodule // tcc_tick_div

`default_nettype wire

// [src/tcc_pin_sync.v]
// three-stage pin synchroniser with agreement-based edge detection
`timescale 1ns/1ps
`default_nettype none

module tcc_pin_sync (
  input wire aclk,
  input wire aresetn,
  input wire pin_in,
  output reg rise,
  output reg fall
);

  reg s1_reg;
  reg s2_reg;
  reg s3_reg;
  reg level_reg;

  // s1 feeds only s2; a change counts once s2 and s3 agree
  always @(posedge aclk) begin
    if (!aresetn) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      level_reg <= 1'b0;
      rise <= 1'b0;
      fall <= 1'b0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      rise <= 1'b0;
      fall <= 1'b0;
      if (s2_reg == s3_reg && s3_reg != level_reg) begin
        level_reg <= s3_reg;
        rise <= s3_reg;
        fall <= ~s3_reg;
      end
    end
  end

endmodule // tcc_pin_sync

`default_nettype wire

// [src/tcc_channel.v]
// timer channel with output compare, input capture and overflow, AXI4-Lite slave
//
// Overview of operation
// - code top bit 0: compare; 0000 holds pin, 0001-0011 start low then 0/1/toggle
// - code 0100 holds pin; 0101-0111 start high then drive 0/1/toggle on match
// - code top bit 1: capture counter on rising, falling or both edges; bit2 ignored
// - pin driven low after reset until software writes the pin control register
// - after reset the counter is free-running with no clearing source
// - counter increments only while its start bit is 1
// - wrap from FFFF to 0000 sets the overflow flag
// - overflow flag with enable bit 1 raises interrupt request; enable 0 none
// - after overflow counting continues from zero while start bit stays set
//
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "tcc_defines.vh"

module tcc_channel #(
  parameter PRESC_W = 16
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire pin_in,
  output reg pin_out,
  output reg pin_oe_n,
  output reg irq
);

  // ****************************************
  // registers and state
  // ****************************************
  reg [7:0] pin_io_control_reg;
  reg ctl_written_reg;
  reg counter_start_reg;
  reg [15:0] channel_counter_reg;
  reg [15:0] ch4_general_reg_a_reg;
  reg [`TCC_NEVENT-1:0] channel_status_reg;
  reg [`TCC_NEVENT-1:0] interrupt_enable_reg;
  reg [PRESC_W-1:0] presc_reg;
  reg [7:0] awaddr_reg;
  reg aw_held_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  reg w_held_reg;

  wire tick;
  wire cap_rise;
  wire cap_fall;

  // ****************************************
  // sub blocks
  // ****************************************
  tcc_tick_div #(
    .WIDTH(PRESC_W)
  ) tcc_tick_div_inst (
    .aclk(aclk),
    .aresetn(aresetn),
    .divisor(presc_reg),
    .tick(tick)
  );

  tcc_pin_sync tcc_pin_sync_inst (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in(pin_in),
    .rise(cap_rise),
    .fall(cap_fall)
  );

  // ****************************************
  // decode of the pin function code
  // ****************************************
  wire [3:0] code = pin_io_control_reg[3:0];
  wire capture_mode = code[`TCC_CODE_TOP];
  wire init_level = code[`TCC_CODE_INIT];
  wire compare_active = ~capture_mode & (code[1:0] != 2'b00);
  wire cap_event = capture_mode & (code[1] ? (cap_rise | cap_fall) :
                   (code[0] ? cap_fall : cap_rise));
  wire wrap = tick & counter_start_reg & (channel_counter_reg == `TCC_COUNT_MAX);
  wire match = tick & counter_start_reg & ~capture_mode &
               (channel_counter_reg == ch4_general_reg_a_reg);

  // ****************************************
  // write channel handling
  // ****************************************
  // response code decided from the held address only;
  // the live bus may already carry the next request
  // by the time both halves are in
  wire wr_known = (awaddr_reg == `TCC_OFF_IOCTL) | (awaddr_reg == `TCC_OFF_START) |
                  (awaddr_reg == `TCC_OFF_COUNT) | (awaddr_reg == `TCC_OFF_GRA) |
                  (awaddr_reg == `TCC_OFF_STATUS) | (awaddr_reg == `TCC_OFF_IRQEN) |
                  (awaddr_reg == `TCC_OFF_PRESC);
  wire [`TCC_NEVENT-1:0] st_set;
  assign st_set[`TCC_ST_MATCH] = match;
  assign st_set[`TCC_ST_OVF] = wrap;
  assign st_set[`TCC_ST_CAPT] = cap_event;

  // address and data may arrive in either order; hold each until both are here
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TCC_RESP_OKAY;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      if (s_axi_awvalid & ~aw_held_reg & ~s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid & ~w_held_reg & ~s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b1;
      end
      if (aw_held_reg & w_held_reg & ~s_axi_bvalid) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? `TCC_RESP_OKAY : `TCC_RESP_SLVERR;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  wire do_write = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  wire wr_start = do_write & (awaddr_reg == `TCC_OFF_START) & wstrb_reg[0];
  wire wr_count = do_write & (awaddr_reg == `TCC_OFF_COUNT);
  wire wr_gra = do_write & (awaddr_reg == `TCC_OFF_GRA);
  wire wr_irqen = do_write & (awaddr_reg == `TCC_OFF_IRQEN) & wstrb_reg[0];
  wire wr_presc = do_write & (awaddr_reg == `TCC_OFF_PRESC);
  wire wr_ctl = do_write & (awaddr_reg == `TCC_OFF_IOCTL) & wstrb_reg[0];
  wire [`TCC_NEVENT-1:0] clr_now = (do_write & (awaddr_reg == `TCC_OFF_STATUS) &
                                   wstrb_reg[0]) ? wdata_reg[`TCC_NEVENT-1:0] :
                                   {`TCC_NEVENT{1'b0}};

  // ****************************************
  // control registers
  // ****************************************
  // free-running after reset: no clearing source exists at all
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_io_control_reg <= `TCC_IOCTL_RST;
      ctl_written_reg <= 1'b0;
      counter_start_reg <= 1'b0;
      interrupt_enable_reg <= {`TCC_NEVENT{1'b0}};
      presc_reg <= `TCC_PRESC_RST;
    end else begin
      if (wr_ctl) begin
        pin_io_control_reg <= wdata_reg[7:0];
        ctl_written_reg <= 1'b1;
      end
      if (wr_start)
        counter_start_reg <= wdata_reg[0];
      if (wr_irqen)
        interrupt_enable_reg <= wdata_reg[`TCC_NEVENT-1:0];
      if (wr_presc)
        presc_reg <= wdata_reg[PRESC_W-1:0];
    end
  end

  // ****************************************
  // counter and general register a
  // ****************************************
  // software write to the counter wins over a tick in the same cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      channel_counter_reg <= 16'h0000;
      ch4_general_reg_a_reg <= `TCC_COUNT_MAX;
    end else begin
      if (wr_count)
        channel_counter_reg <= wdata_reg[15:0];
      else if (tick & counter_start_reg)
        channel_counter_reg <= channel_counter_reg + 16'h0001;
      if (cap_event)
        ch4_general_reg_a_reg <= channel_counter_reg;
      else if (wr_gra)
        ch4_general_reg_a_reg <= wdata_reg[15:0];
    end
  end

  // ****************************************
  // status flags and interrupt
  // ****************************************
  // write-one-to-clear; a setting event in the same cycle wins
  genvar gi;
  generate
    for (gi = 0; gi < `TCC_NEVENT; gi = gi + 1) begin : g_flag
      always @(posedge aclk) begin
        if (!aresetn)
          channel_status_reg[gi] <= 1'b0;
        else if (st_set[gi])
          channel_status_reg[gi] <= 1'b1;
        else if (clr_now[gi])
          channel_status_reg[gi] <= 1'b0;
      end
    end
  endgenerate

  // level request while any enabled flag stands
  always @(posedge aclk) begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= |(channel_status_reg & interrupt_enable_reg);
  end

  // ****************************************
  // compare pin
  // ****************************************
  // low from reset until first control write, even under hold code
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_out <= 1'b0;
      pin_oe_n <= 1'b0;
    end else if (wr_ctl) begin
      pin_oe_n <= wdata_reg[`TCC_CODE_TOP];
      if (wdata_reg[1:0] != 2'b00 && !wdata_reg[`TCC_CODE_TOP])
        pin_out <= wdata_reg[`TCC_CODE_INIT];
    end else if (ctl_written_reg & compare_active & match) begin
      case (code[1:0])
        2'b01: pin_out <= 1'b0;
        2'b10: pin_out <= 1'b1;
        2'b11: pin_out <= ~pin_out;
        default: pin_out <= pin_out;
      endcase
    end
  end

  // ****************************************
  // read channel
  // ****************************************
  reg [31:0] rd_mux;
  always @* begin
    case (s_axi_araddr)
      `TCC_OFF_IOCTL: rd_mux = {24'h000000, pin_io_control_reg};
      `TCC_OFF_START: rd_mux = {31'h00000000, counter_start_reg};
      `TCC_OFF_COUNT: rd_mux = {16'h0000, channel_counter_reg};
      `TCC_OFF_GRA: rd_mux = {16'h0000, ch4_general_reg_a_reg};
      `TCC_OFF_STATUS: rd_mux = {29'h00000000, channel_status_reg};
      `TCC_OFF_IRQEN: rd_mux = {29'h00000000, interrupt_enable_reg};
      `TCC_OFF_PRESC: rd_mux = {{(32-PRESC_W){1'b0}}, presc_reg};
      default: rd_mux = 32'h00000000;
    endcase
  end

  wire rd_known = (s_axi_araddr == `TCC_OFF_IOCTL) | (s_axi_araddr == `TCC_OFF_START) |
                  (s_axi_araddr == `TCC_OFF_COUNT) | (s_axi_araddr == `TCC_OFF_GRA) |
                  (s_axi_araddr == `TCC_OFF_STATUS) | (s_axi_araddr == `TCC_OFF_IRQEN) |
                  (s_axi_araddr == `TCC_OFF_PRESC);

  // one read at a time; address taken and data returned on the next edge
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `TCC_RESP_OKAY;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_rvalid) begin
        if (s_axi_rready)
          s_axi_rvalid <= 1'b0;
      end else if (s_axi_arvalid & ~s_axi_arready) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_known ? `TCC_RESP_OKAY : `TCC_RESP_SLVERR;
      end
    end
  end

endmodule // tcc_channel

`default_nettype wire

// [sim/tcc_channel_properties.sv]
// assertion checker for the timer channel bus, pin and interrupt ports
`timescale 1ns/1ps
`default_nettype none

module tcc_channel_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pin_out,
  input wire logic pin_oe_n,
  input wire logic irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ****
  // bus steps
  // ****
  // the no-bvalid term keeps an overlapping next address out
  sequence s_wr_req;
    s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  endsequence
  sequence s_wr_ack;
    s_axi_awready && s_axi_wready ##1 s_axi_bvalid;
  endsequence
  sequence s_rd_req;
    s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
  endsequence
  sequence s_rd_ack;
    s_axi_arready && s_axi_rvalid ##1 !s_axi_arready;
  endsequence
  // ****
  // properties
  // ****
  AST_WR_ANSWER: assert property (s_wr_req |=> s_wr_ack)
    else $error("write not answered in two cycles");
  AST_RD_ANSWER: assert property (s_rd_req |=> s_rd_ack)
    else $error("read not answered in one cycle");
  AST_B_STANDS: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  AST_R_STANDS: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  AST_WR_UNMAPPED: assert property (s_axi_awready && s_axi_wready && s_axi_awaddr > 8'h18
    |=> s_axi_bvalid && s_axi_bresp == 2'h2) else $error("unmapped write not refused");
  AST_RD_UNMAPPED: assert property (s_axi_arready && s_axi_araddr > 8'h18
    |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
  AST_RST_PIN_LOW: assert property ($rose(aresetn) |-> !pin_out && !pin_oe_n && !irq)
    else $error("pin or irq wrong after reset");
  AST_OE_BY_WRITE: assert property ($changed(pin_oe_n) |->
    $past(s_axi_wready) || $past(s_axi_wready, 2) || $past(s_axi_wready, 3))
    else $error("pin direction changed without a write");
endmodule // tcc_channel_props

bind tcc_channel tcc_channel_props tcc_channel_props_inst (.*);

`default_nettype wire

// [sim/tcc_pin_model.sv]
// external signal source on the channel compare/capture pin
`timescale 1ns/1ps
`default_nettype none

module tcc_pin_model (
  input wire logic drv,
  input wire logic pin_out,
  input wire logic pin_oe_n,
  output logic pin_in
);
  // the wire follows the device while it drives, else the outside source
  assign pin_in = pin_oe_n ? drv : pin_out;
endmodule // tcc_pin_model

`default_nettype wire

// [sim/test_timer_channel_capture_compare.sv]
// self-checking testbench for the timer capture/compare channel
`timescale 1ns/1ps
`default_nettype none
`include "tcc_defines.vh"

module test_timer_channel_capture_compare;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, drv;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, rv, rw, e;
  logic [3:0] s_axi_wstrb;
  logic [1:0] rr;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire pin_out, pin_oe_n, irq, pin_in;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  int num_errors, cmp_count, i;

  tcc_channel tcc_channel_inst (.*);
  tcc_pin_model tcc_pin_model_inst (.drv(drv), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_in(pin_in));

  // ****
  // helpers
  // ****
  task test_done;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task chk(input string s, input [31:0] x, input [31:0] g);
    cmp_count++;
    if (g !== x) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", s, x, g);
    end
  endtask

  // answers sampled at the rising edge; each valid drops right after its handshake
  task automatic wr(input [7:0] a, input [31:0] d, output [1:0] r);
    int n;
    logic ka, kw, kb;
    n = 0;
    kb = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (kb !== 1'b1 && n < 50) begin
      @(posedge aclk);
      ka = s_axi_awready;
      kw = s_axi_wready;
      kb = s_axi_bvalid;
      r = s_axi_bresp;
      if (ka) s_axi_awvalid <= 1'b0;
      if (kw) s_axi_wvalid <= 1'b0;
      n++;
    end
    s_axi_bready <= 1'b0;
    if (kb !== 1'b1) begin
      num_errors++;
      $display("mismatch bvalid expected 1 seen 0");
    end
  endtask

  task w(input [7:0] a, input [31:0] d);
    wr(a, d, rr);
  endtask

  task automatic rd(input [7:0] a, output [31:0] d, output [1:0] r);
    int n;
    logic ka, kr;
    n = 0;
    kr = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (kr !== 1'b1 && n < 50) begin
      @(posedge aclk);
      ka = s_axi_arready;
      kr = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      if (ka) s_axi_arvalid <= 1'b0;
      n++;
    end
    s_axi_rready <= 1'b0;
    if (kr !== 1'b1) begin
      num_errors++;
      $display("mismatch rvalid expected 1 seen 0");
    end
  endtask

  // ****
  // clock and watchdog
  // ****
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // the whole run needs under a thousand cycles
  initial begin
    #750000;
    num_errors++;
    test_done;
  end

  // ****
  // tests
  // ****
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
    drv = 1'b0;
    num_errors = 0;
    cmp_count = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk("pin_out", 0, pin_out);
    chk("pin_oe_n", 0, pin_oe_n);
    repeat (20) @(posedge aclk);
    rd(`TCC_OFF_COUNT, rv, rr);
    chk("count stopped", 0, rv);
    // overflow with interrupt masked, then unmasked, then cleared
    w(`TCC_OFF_IRQEN, 32'h0);
    w(`TCC_OFF_COUNT, 32'hFFF0);
    w(`TCC_OFF_START, 32'h1);
    repeat (40) @(posedge aclk);
    chk("irq masked", 0, irq);
    rd(`TCC_OFF_STATUS, rv, rr);
    chk("overflow flag", 1, rv[1]);
    rd(`TCC_OFF_COUNT, rv, rr);
    chk("count wrapped", 1, rv > 32'h0 && rv < 32'h40);
    w(`TCC_OFF_IRQEN, 32'h2);
    repeat (3) @(posedge aclk);
    chk("irq raised", 1, irq);
    w(`TCC_OFF_STATUS, 32'h2);
    repeat (3) @(posedge aclk);
    chk("irq cleared", 0, irq);
    w(`TCC_OFF_START, 32'h0);
    rd(`TCC_OFF_COUNT, rw, rr);
    rd(`TCC_OFF_COUNT, rv, rr);
    chk("count held", rw, rv);
    // compare codes; codes 4 and 0 follow a level of 1 so holding shows
    for (i = 0; i < 8; i++) begin
      w(`TCC_OFF_GRA, 32'h100);
      w(`TCC_OFF_COUNT, 32'hF0);
      w(`TCC_OFF_IOCTL, (32'h04675321 >> (4 * i)) & 32'hF);
      repeat (2) @(posedge aclk);
      chk("initial level", (8'hF8 >> i) & 1, pin_out);
      chk("pin_oe_n", 0, pin_oe_n);
      w(`TCC_OFF_START, 32'h1);
      repeat (30) @(posedge aclk);
      w(`TCC_OFF_START, 32'h0);
      chk("match level", (8'hE6 >> i) & 1, pin_out);
    end
    rd(`TCC_OFF_COUNT, rv, rr);
    chk("no clear on match", 1, rv > 32'h100);
    // capture codes with the counter stopped at a known value
    w(`TCC_OFF_IOCTL, 32'h8);
    repeat (2) @(posedge aclk);
    chk("pin_oe_n", 1, pin_oe_n);
    e = 32'h100;
    for (i = 0; i < 8; i++) begin
      w(`TCC_OFF_IOCTL, (32'hDEAA9988 >> (4 * i)) & 32'hF);
      w(`TCC_OFF_COUNT, 32'h1111 * (i + 1));
      @(posedge aclk);
      drv <= ~i[0];
      repeat (8) @(posedge aclk);
      if ((8'hF9 >> i) & 1) e = 32'h1111 * (i + 1);
      rd(`TCC_OFF_GRA, rv, rr);
      chk("capture", e, rv);
    end
    // prescaler 3: one tick in four over the 44 enabled edges of a start/stop pair
    w(`TCC_OFF_PRESC, 32'h3);
    w(`TCC_OFF_COUNT, 32'h0);
    w(`TCC_OFF_START, 32'h1);
    repeat (40) @(posedge aclk);
    w(`TCC_OFF_START, 32'h0);
    rd(`TCC_OFF_COUNT, rv, rr);
    chk("prescaled count", 11, rv);
    // unmapped place
    wr(8'h1C, 32'h5A, rr);
    chk("bresp", `TCC_RESP_SLVERR, rr);
    rd(8'h1C, rv, rr);
    chk("rresp", `TCC_RESP_SLVERR, rr);
    chk("rdata", 0, rv);
    test_done;
  end
endmodule // test_timer_channel_capture_compare

`default_nettype wire
